/* design/dcc_pkg.sv */
/*
 * Package for the dc-dc converter control register bank: special-function
 * page and addresses, field positions, reset values, timing counts and the
 * carrier struct of the register access port.
 * Assumes a single 200 MHz system clock and an 8-bit register port.
 */
package dcc_pkg;

   // Special-function page and addresses
   localparam logic [7:0] SFR_PAGE      = 8'h00;
   localparam logic [7:0] ADDR_CONTROL  = 8'h97;
   localparam logic [7:0] ADDR_CONFIG   = 8'h96;
   localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

   // Reset values
   localparam logic [7:0] CONTROL_RESET = 8'h21;
   localparam logic [7:0] CONFIG_RESET  = 8'h00;

   // Control register fields
   localparam int CTL_PULSE_LSB = 6;
   localparam int CTL_SWITCH    = 5;
   localparam int CTL_RSVD      = 4;
   localparam int CTL_SYNC      = 3;
   localparam int CTL_VOLT_LSB  = 0;

   // Configuration register fields
   localparam int CFG_RSVD      = 7;
   localparam int CFG_DIV_LSB   = 5;
   localparam int CFG_ADCINV    = 4;
   localparam int CFG_CLK_INV   = 3;
   localparam int CFG_PEAK      = 2;
   localparam int CFG_SLPFLOAT  = 1;
   localparam int CFG_CLKSRC    = 0;

   // Writable bit masks (reserved bits never stored)
   localparam logic [7:0] CONTROL_WMASK = 8'hEF;
   localparam logic [7:0] CONFIG_WMASK  = 8'h7F;

   // Minimum pulse widths and their cycle counts, rounded up
   localparam int CLK_PERIOD_PS = 5000;
   localparam int PULSE1_NS     = 20;
   localparam int PULSE2_NS     = 40;
   localparam int PULSE3_NS     = 80;
   localparam logic [4:0] PULSE1_CYC =
      5'((PULSE1_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [4:0] PULSE2_CYC =
      5'((PULSE2_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [4:0] PULSE3_CYC =
      5'((PULSE3_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

   // Output voltage targets in millivolts, indexed by the field code
   localparam logic [11:0] VOLT_MV [8] = '{
      12'h708, 12'h76C, 12'h7D0, 12'h834,
      12'h960, 12'hA8C, 12'hA8C, 12'hCE4};

   // Register access request from the core
   typedef struct packed {
      logic [7:0] page;
      logic [7:0] addr;
      logic       wr;
      logic       rd;
      logic [7:0] wdata;
   } dcc_sfr_req_s;

endpackage

/* design/dcc_regs.sv */
/*
 * Dc-dc converter control and configuration register bank with the
 * converter clock tick generator, ADC synchronisation controls and
 * sleep-mode output connection.
 * Assumes one core on the register port, same clock as mclk; the local
 * oscillator arrives asynchronously and is synchronised here.
 */
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// R1: pulse-width code selects none, 20, 40, 80 ns
// R2: switch bit 0 large, 1 small; resets 1
// R3: software clears ADC sample-clock field before sync
// R4: sync places tracking in quiet interval, aligns SAR
// R5: sync off runs ADC independently; off at reset
// R6: sync behaviour only on supporting silicon revisions
// R7: voltage code selects 1.8 to 3.3 V
// R8: control at page 0, address 0x97, resets 0x21
// R9: configuration at 0x96, resets zero, bit 7 read-only
// R10: divide by 1, 2, 4, 8; oscillator ignores
// R11: bit 0 picks clock source; bit 3 inverts, system source only
// R12: bit 4 low inverts SAR clock, sync only
// R13: sleep float or battery; bit 2 current limit
// R14: reserved bits written zero, read back zero
module dcc_regs #(
   parameter bit SYNC_SUPPORTED = 1'b1
) (
   // Clock and reset
   input  wire logic                 mclk,
   input  wire logic                 arst_n,
   // Register access port
   input  wire dcc_pkg::dcc_sfr_req_s sfr_req,
   output logic [7:0]                sfr_rdata,
   // Converter clocking
   input  wire logic                 local_osc,
   output logic                      conv_tick,
   output logic                      conv_phase,
   // Converter settings
   output logic [4:0]                min_pulse_cycles,
   output logic                      switch_size_sel,
   output logic [11:0]               output_voltage_mv,
   output logic                      peak_current_level,
   // ADC synchronisation
   output logic                      adc_sync_active,
   output logic                      adc_track_allow,
   output logic                      adc_sar_clock_invert,
   // Sleep connection
   input  wire logic                 sleep,
   output logic                      vdd_to_battery,
   output logic                      sleep_output_float
);

   logic [7:0] converter_control;
   logic [7:0] converter_configuration;
   logic       osc_meta;
   logic       osc_sync;
   logic       osc_prev;
   logic [2:0] div_cnt;
   logic       phase;

   // Address decode
   wire page_hit  = (sfr_req.page == dcc_pkg::SFR_PAGE);
   wire ctl_hit   = page_hit && (sfr_req.addr == dcc_pkg::ADDR_CONTROL);
   wire cfg_hit   = page_hit && (sfr_req.addr == dcc_pkg::ADDR_CONFIG);
   wire ctl_wr    = sfr_req.wr && ctl_hit;
   wire cfg_wr    = sfr_req.wr && cfg_hit;

   // Field views
   wire [1:0] pulse_code  = converter_control[dcc_pkg::CTL_PULSE_LSB +: 2];
   wire       sync_bit    = converter_control[dcc_pkg::CTL_SYNC];
   wire [2:0] volt_code   = converter_control[dcc_pkg::CTL_VOLT_LSB +: 3];
   wire [1:0] div_code    = converter_configuration[dcc_pkg::CFG_DIV_LSB +: 2];
   wire       clk_src_sys = converter_configuration[dcc_pkg::CFG_CLKSRC];
   wire       clk_inv     = converter_configuration[dcc_pkg::CFG_CLK_INV];
   wire       adc_inv_bit = converter_configuration[dcc_pkg::CFG_ADCINV];
   wire       sync_on     = sync_bit && SYNC_SUPPORTED; // R6

   // Read data selection; reserved bits are never stored
   wire [7:0] next_rdata = ctl_hit ? converter_control :
                           cfg_hit ? converter_configuration :
                           dcc_pkg::RDATA_UNMAPPED; // R14

   // Divider limit from the divider code
   wire [2:0] div_limit = 3'((4'h1 << div_code) - 4'h1); // R10
   wire       sys_tick  = (div_cnt >= div_limit);
   wire       osc_rise  = osc_sync && !osc_prev;
   wire       next_tick = clk_src_sys ? sys_tick : osc_rise; // R11

   // Minimum pulse width count
   wire [4:0] next_pulse = (pulse_code == 2'b01) ? dcc_pkg::PULSE1_CYC :
                           (pulse_code == 2'b10) ? dcc_pkg::PULSE2_CYC :
                           (pulse_code == 2'b11) ? dcc_pkg::PULSE3_CYC :
                           5'h00; // R1

   // Quiet half of the switching cycle allows tracking when synced
   wire next_phase_out = phase ^ (clk_src_sys && clk_inv); // R11
   wire next_track     = !sync_on || next_phase_out; // R4 R5
   wire next_sar_inv   = sync_on && !adc_inv_bit; // R12

   // Register writes
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         converter_control       <= dcc_pkg::CONTROL_RESET; // R8 R2 R5
         converter_configuration <= dcc_pkg::CONFIG_RESET;  // R9
      end else begin
         if (ctl_wr) begin
            converter_control <= sfr_req.wdata & dcc_pkg::CONTROL_WMASK; // R8
         end
         if (cfg_wr) begin
            converter_configuration <=
               sfr_req.wdata & dcc_pkg::CONFIG_WMASK; // R9
         end
      end
   end

   // Read data register
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         sfr_rdata <= dcc_pkg::RDATA_UNMAPPED;
      end else if (sfr_req.rd) begin
         sfr_rdata <= next_rdata;
      end
   end

   // Local oscillator synchroniser
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         osc_meta <= 1'b0;
         osc_sync <= 1'b0;
         osc_prev <= 1'b0;
      end else begin
         osc_meta <= local_osc;
         osc_sync <= osc_meta;
         osc_prev <= osc_sync;
      end
   end

   // System clock divider and switching phase
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         div_cnt <= 3'h0;
         phase   <= 1'b0;
      end else begin
         div_cnt <= (sys_tick || !clk_src_sys) ? 3'h0 : div_cnt + 3'h1; // R10
         if (next_tick) begin
            phase <= !phase;
         end
      end
   end

   // Registered outputs
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         conv_tick            <= 1'b0;
         conv_phase           <= 1'b0;
         min_pulse_cycles     <= 5'h00;
         switch_size_sel      <= 1'b1;
         output_voltage_mv    <= dcc_pkg::VOLT_MV[1];
         peak_current_level   <= 1'b0;
         adc_sync_active      <= 1'b0;
         adc_track_allow      <= 1'b1;
         adc_sar_clock_invert <= 1'b0;
         vdd_to_battery       <= 1'b0;
         sleep_output_float   <= 1'b0;
      end else begin
         conv_tick            <= next_tick;
         conv_phase           <= next_phase_out;
         min_pulse_cycles     <= next_pulse; // R1
         switch_size_sel      <= converter_control[dcc_pkg::CTL_SWITCH]; // R2
         output_voltage_mv    <= dcc_pkg::VOLT_MV[volt_code]; // R7
         peak_current_level   <=
            converter_configuration[dcc_pkg::CFG_PEAK]; // R13
         adc_sync_active      <= sync_on; // R4 R5
         adc_track_allow      <= next_track; // R4
         adc_sar_clock_invert <= next_sar_inv; // R12
         vdd_to_battery       <= sleep &&
            !converter_configuration[dcc_pkg::CFG_SLPFLOAT]; // R13
         sleep_output_float   <= sleep &&
            converter_configuration[dcc_pkg::CFG_SLPFLOAT]; // R13
      end
   end

   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);

   pulse_map_a: assert property ( // R1
      ctl_wr && sfr_req.wdata[7:6] == 2'b11
      |=> ##1 min_pulse_cycles == 5'h10)
      else $error("pulse width count wrong for code 3");
   switch_out_a: assert property ( // R2
      ctl_wr |=> ##1 switch_size_sel == $past(sfr_req.wdata[5], 2))
      else $error("switch select does not follow write");
   sync_track_a: assert property ( // R4
      adc_sync_active && !converter_control[3] |=> ##[0:1] !adc_sync_active)
      else $error("sync stays on after clear");
   nosync_free_a: assert property ( // R5
      !sync_on ##1 !sync_on |=> adc_track_allow && !adc_sar_clock_invert)
      else $error("ADC constrained while unsynchronised");
   volt_map_a: assert property ( // R7
      ctl_wr && sfr_req.wdata[2:0] == 3'b111
      |=> ##1 output_voltage_mv == 12'hCE4)
      else $error("voltage target for code 7 wrong");
   ctl_read_a: assert property ( // R8
      sfr_req.rd && ctl_hit && !ctl_wr
      |=> sfr_rdata == $past(converter_control))
      else $error("control readback mismatch");
   cfg_rsvd_a: assert property ( // R9
      sfr_req.rd && cfg_hit |=> !sfr_rdata[7])
      else $error("configuration bit 7 reads one");
   div_rate_a: assert property ( // R10
      clk_src_sys && div_code == 2'b11 && sys_tick ##1
      (clk_src_sys && div_code == 2'b11)[*7] |=> sys_tick)
      else $error("divide by eight period wrong");
   osc_ignore_a: assert property ( // R11
      !clk_src_sys |-> div_cnt == 3'h0 || $past(clk_src_sys))
      else $error("divider runs on local oscillator");
   sar_inv_a: assert property ( // R12
      sync_on && !adc_inv_bit ##1 sync_on && !adc_inv_bit
      |=> adc_sar_clock_invert)
      else $error("SAR clock not inverted");
   sleep_conn_a: assert property ( // R13
      sleep |=> vdd_to_battery ^ sleep_output_float)
      else $error("sleep output not exactly one of float and battery");
   ctl_rsvd_a: assert property ( // R14
      !converter_control[4])
      else $error("reserved control bit stored");

   sync_on_c:   cover property (ctl_wr && sfr_req.wdata[3]);
   sys_div8_c:  cover property (clk_src_sys && div_code == 2'b11 && sys_tick);
   osc_tick_c:  cover property (!clk_src_sys && conv_tick);
   sleep_flt_c: cover property (sleep_output_float);

endmodule

`default_nettype wire

/* verification/dcc_regs_test.sv */
/*
 * Self-checking bench for the converter register bank: reset values, then a table
 * of control writes, bank masking, unmapped access, sleep, clocking and a mid-run reset.
 * Assumes the design's registered read data and two-edge output latency.
 */
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin \
   bad_count++; $display("[FAIL] %s exp %0h got %0h", nm, exp, got); end end

module dcc_regs_test;
   logic                 mclk, arst_n, local_osc, sleep;
   dcc_pkg::dcc_sfr_req_s req;
   logic [7:0]           rdata;
   logic                 tick, phase, sw, peak, sync, track, sinv;
   logic                 vbat, flt;
   logic [4:0]           pc;
   logic [11:0]          mv;
   int                   bad_count, cmp_count, n;
   // Table rows: control byte, target millivolts, pulse cycles
   logic [7:0]  r_d [8] = '{8'h00, 8'h51, 8'h92, 8'hF3,
                            8'h14, 8'h6D, 8'hAE, 8'hEF};
   logic [11:0] r_v [8] = '{12'd1800, 12'd1900, 12'd2000, 12'd2100,
                            12'd2400, 12'd2700, 12'd2700, 12'd3300};
   logic [4:0]  r_p [8] = '{5'd0, 5'd4, 5'd8, 5'd16,
                            5'd0, 5'd4, 5'd8, 5'd16};

   dcc_regs dcc_regs_i (.mclk(mclk), .arst_n(arst_n), .sfr_req(req),
      .sfr_rdata(rdata), .local_osc(local_osc), .conv_tick(tick),
      .conv_phase(phase), .min_pulse_cycles(pc), .switch_size_sel(sw),
      .output_voltage_mv(mv), .peak_current_level(peak),
      .adc_sync_active(sync), .adc_track_allow(track),
      .adc_sar_clock_invert(sinv), .sleep(sleep),
      .vdd_to_battery(vbat), .sleep_output_float(flt));

   // Clock and free-running local oscillator, 16 mclk periods
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   initial begin
      local_osc = 1'b0;
      forever #40 local_osc = ~local_osc;
   end

   // Single-byte write; request held to the taking edge
   task automatic wr(input logic [7:0] pg, input logic [7:0] ad,
                     input logic [7:0] d);
      @(posedge mclk);
      req.page <= pg;
      req.addr <= ad;
      req.wdata <= d;
      req.wr <= 1'b1;
      @(posedge mclk);
      req.wr <= 1'b0;
   endtask

   // Write then let the derived outputs settle
   task automatic wrs(input logic [7:0] ad, input logic [7:0] d);
      wr(8'h00, ad, d);
      repeat (2) @(posedge mclk);
      #1;
   endtask

   // Single-byte read, data taken after the answering edge
   task automatic rd(input logic [7:0] ad, output logic [7:0] d);
      @(posedge mclk);
      req.page <= 8'h00;
      req.addr <= ad;
      req.rd <= 1'b1;
      @(posedge mclk);
      req.rd <= 1'b0;
      #1 d = rdata;
   endtask

   // Ticks seen in a window of w cycles
   task automatic ticks(input int w, output int c);
      c = 0;
      repeat (w) begin
         @(posedge mclk);
         #1 if (tick === 1'b1) c++;
      end
   endtask

   task automatic summarize();
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // Watchdog
   initial begin
      repeat (20000) @(posedge mclk);
      bad_count++;
      summarize();
   end

   initial begin
      logic [7:0] d;
      logic       p;
      arst_n = 1'b0;
      sleep = 1'b0;
      req = '0;
      repeat (10) @(posedge mclk);
      arst_n <= 1'b1;
      #1;
      `CHK("rst_volt", 12'd1900, mv)
      `CHK("rst_switch", 1'b1, sw)
      `CHK("rst_sync", 1'b0, sync)
      `CHK("rst_track", 1'b1, track)
      rd(8'h97, d);
      `CHK("rst_ctl", 8'h21, d)
      rd(8'h96, d);
      `CHK("rst_cfg", 8'h00, d)
      // Table of control settings
      for (int i = 0; i < 8; i++) begin
         // Sync rows take the ADC sample-clock field as already zero
         wrs(8'h97, r_d[i]);
         `CHK("volt", r_v[i], mv)
         `CHK("pulse", r_p[i], pc)
         `CHK("switch", r_d[i][5], sw)
         `CHK("sync", r_d[i][3], sync)
         if (r_d[i][3] === 1'b0) `CHK("track", 1'b1, track)
         else `CHK("track_sync", phase, track)
         rd(8'h97, d);
         `CHK("ctl_rd", r_d[i] & 8'hEF, d)
      end
      // Wrong page and unmapped address are ignored
      wr(8'h01, 8'h97, 8'h00);
      rd(8'h97, d);
      `CHK("page", 8'hEF, d)
      wr(8'h00, 8'h95, 8'hFF);
      rd(8'h95, d);
      `CHK("unmapped", 8'h00, d)
      // Configuration: read-only bit 7, limit, SAR inversion, sleep
      @(posedge mclk);
      sleep <= 1'b1;
      wrs(8'h96, 8'hFF);
      rd(8'h96, d);
      `CHK("cfg_rd", 8'h7F, d)
      `CHK("peak", 1'b1, peak)
      `CHK("float", 1'b1, flt)
      `CHK("sinv1", 1'b0, sinv)
      wrs(8'h96, 8'h00);
      `CHK("vbat", 1'b1, vbat)
      `CHK("sinv0", 1'b1, sinv)
      wrs(8'h97, 8'h00);
      `CHK("sinv_off", 1'b0, sinv)
      // Divider on system clock, then ignored on local oscillator
      for (int k = 0; k < 4; k++) begin
         wrs(8'h96, 8'h01 | 8'(k << 5));
         repeat (4) @(posedge mclk);
         ticks(32, n);
         `CHK("div", 32 >> k, n)
      end
      // Invert on system source flips phase over two whole periods
      @(posedge mclk);
      #1 p = phase;
      wr(8'h00, 8'h96, 8'h69);
      repeat (14) @(posedge mclk);
      #1;
      `CHK("clk_inv", !p, phase)
      wrs(8'h96, 8'h60);
      repeat (8) @(posedge mclk);
      ticks(160, n);
      `CHK("osc", 10, n)
      // Reset in mid-run restores both registers
      @(posedge mclk);
      arst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      arst_n <= 1'b1;
      #1;
      `CHK("rst2_volt", 12'd1900, mv)
      rd(8'h97, d);
      `CHK("rst2_ctl", 8'h21, d)
      rd(8'h96, d);
      `CHK("rst2_cfg", 8'h00, d)
      summarize();
   end
endmodule

`default_nettype wire
